// ---- rtl/lrc_map.vh ----
`ifndef LRC_MAP_VH
`define LRC_MAP_VH
// Register word indexes; the byte address on the bus is four times the index
`define LRC_IDX_PORT_A_DIR 8'h85
`define LRC_IDX_REF_CTRL 8'h9f
`define LRC_IDX_CMP_CTRL 8'h1f
`define LRC_ADDR_PORT_A_DIR 12'h214
`define LRC_ADDR_REF_CTRL 12'h27c
`define LRC_ADDR_CMP_CTRL 12'h07c
// Reset values
`define LRC_RST_PORT_A_DIR 8'h1f
`define LRC_RST_REF_CTRL 8'h00
`define LRC_RST_CMP_CTRL 8'h00
// Implemented bit masks
`define LRC_MASK_PORT_A_DIR 8'h1f
`define LRC_MASK_REF_CTRL 8'hef
`define LRC_MASK_CMP_CTRL 8'h0f
// Reference control fields
`define LRC_BIT_POWER 7
`define LRC_BIT_PIN_DRIVE 6
`define LRC_BIT_LOW_RANGE 5
`define LRC_TAP_MSB 3
`define LRC_TAP_LSB 0
// Port A direction bit for pin 2
`define LRC_BIT_PIN2_DIR 2
// Comparator config that routes the ladder to both comparators
`define LRC_CMP_CFG_INTREF 3'h2
// Settling hint for software, in microseconds, and in cycles at 10 MHz
`define LRC_SETTLE_US 10
`define LRC_CLK_MHZ 10
`define LRC_SETTLE_CYC (`LRC_SETTLE_US * `LRC_CLK_MHZ)
// AXI responses
`define LRC_RESP_OKAY 2'h0
`define LRC_RESP_SLVERR 2'h2
`endif

// ---- rtl/lrc_ladder_code.v ----
`include "lrc_map.vh"
// Turns range and tap into ladder output as a fraction of supply, in 96ths.
// Low range: tap/24 = 4*tap/96. High range: 1/4 + tap/32 = (24 + 3*tap)/96.
module lrc_ladder_code (
  input wire ref_clk,
  input wire arst_n,
  input wire power_on,
  input wire low_range,
  input wire [3:0] tap_code,
  output reg [6:0] level_96ths_q
);
  reg [6:0] level_d;

  // Fraction of supply; zero while powered down
  always @* begin
    if (!power_on) begin
      level_d = 7'h00;
    end else if (low_range) begin
      level_d = {1'b0, tap_code, 2'b00};
    end else begin
      level_d = 7'h18 + {2'h0, tap_code, 1'b0} + {3'h0, tap_code};
    end
  end

  // Registered so the analog side sees a clean static code
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      level_96ths_q <= 7'h00;
    end else begin
      level_96ths_q <= level_d;
    end
  end
endmodule

// ---- rtl/lrc_regs.v ----
`include "lrc_map.vh"
// Holds the three control registers; writes masked to implemented bits.
module lrc_regs (
  input wire ref_clk,
  input wire arst_n,
  input wire wr_en,
  input wire [9:0] wr_addr,
  input wire [7:0] wr_data,
  output reg [7:0] ref_ctrl_q,
  output reg [7:0] port_a_dir_q,
  output reg [7:0] cmp_ctrl_q
);
  // Only a device reset touches these; sleep wake-up has no path here
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_ctrl_q <= `LRC_RST_REF_CTRL;
      port_a_dir_q <= `LRC_RST_PORT_A_DIR;
      cmp_ctrl_q <= `LRC_RST_CMP_CTRL;
    end else if (wr_en) begin
      if (wr_addr == {2'h0, `LRC_IDX_REF_CTRL}) begin
        ref_ctrl_q <= wr_data & `LRC_MASK_REF_CTRL;
      end
      if (wr_addr == {2'h0, `LRC_IDX_PORT_A_DIR}) begin
        port_a_dir_q <= wr_data & `LRC_MASK_PORT_A_DIR;
      end
      if (wr_addr == {2'h0, `LRC_IDX_CMP_CTRL}) begin
        cmp_ctrl_q <= wr_data & `LRC_MASK_CMP_CTRL;
      end
    end
  end
endmodule

// ---- rtl/lrc_ladder_reference_control.v ----
`include "lrc_map.vh"
// How it works
// - Bit 7 of the reference control register powers the ladder on when set and off when clear.
// - Bit 6 connects the ladder output toward port pin 2 when set.
// - Bit 5 picks the low range when set and the high range when clear.
// - Bit 4 is not implemented and always reads zero.
// - Bits 3 to 0 are the tap code, 0 to 15, giving 16 levels per range.
// - High range output is a quarter of supply plus tap divided by 32 times supply.
// - Any device reset clears every implemented reference control bit.
// - Sleep wake-up by interrupt or watchdog leaves the register unchanged.
// - The ladder reaches pin 2 only when the pin 2 direction bit and pin drive bit are both set.
// - The reference works independently of the comparator mode.
// - Port A direction holds bits 4 to 0, reset to ones, bits 7 to 5 read zero.
// - Comparator config 010 routes the ladder to both comparators' non-inverting inputs.
module lrc_ladder_reference_control (
  input wire ref_clk,
  input wire arst_n,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg ladder_power_q,
  output reg ladder_pin_drive_q,
  output reg ladder_low_range_q,
  output reg [3:0] ladder_tap_code_q,
  output reg port_a_pin2_connect_q,
  output reg cmp_vin_plus_ref_q,
  output reg [4:0] port_a_direction_q,
  output reg [2:0] comparator_config_q,
  output reg [6:0] ladder_level_96ths_q
);
  // Write channel state
  reg [11:0] aw_addr_q;
  reg aw_have_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg w_have_q;
  wire wr_fire;
  wire wr_hit;
  wire [7:0] ref_ctrl;
  wire [7:0] port_a_dir;
  wire [7:0] cmp_ctrl;
  wire [6:0] level_w;
  reg [31:0] rd_data_d;
  reg rd_hit_d;

  // Reset image of the direction register, narrowed to its five live bits below
  localparam [7:0] DIR_RST = `LRC_RST_PORT_A_DIR;

  // Word select shared by read and write paths: 0 none, 1 ref ctrl, 2 port A dir, 3 cmp ctrl.
  // Only the word index counts; the two low byte bits are ignored, as every register is a word.
  function [1:0] reg_sel;
    input [11:0] addr;
    begin
      if (addr[11:2] == {2'h0, `LRC_IDX_REF_CTRL}) begin
        reg_sel = 2'h1;
      end else if (addr[11:2] == {2'h0, `LRC_IDX_PORT_A_DIR}) begin
        reg_sel = 2'h2;
      end else if (addr[11:2] == {2'h0, `LRC_IDX_CMP_CTRL}) begin
        reg_sel = 2'h3;
      end else begin
        reg_sel = 2'h0;
      end
    end
  endfunction

  // An unmapped word answers with an error response instead of being dropped quietly,
  // so software that strays off the map learns of it at once
  function mapped;
    input [11:0] addr;
    begin
      mapped = (reg_sel(addr) != 2'h0);
    end
  endfunction

  // Registers are 8 bits wide, so only lane 0 carries a write
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_hit = wr_fire && mapped(aw_addr_q) && w_strb_q[0];

  lrc_regs u_regs (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .wr_en(wr_hit),
    .wr_addr(aw_addr_q[11:2]),
    .wr_data(w_data_q[7:0]),
    .ref_ctrl_q(ref_ctrl),
    .port_a_dir_q(port_a_dir),
    .cmp_ctrl_q(cmp_ctrl)
  );

  lrc_ladder_code u_code (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .power_on(ref_ctrl[`LRC_BIT_POWER]),
    .low_range(ref_ctrl[`LRC_BIT_LOW_RANGE]),
    .tap_code(ref_ctrl[`LRC_TAP_MSB:`LRC_TAP_LSB]),
    .level_96ths_q(level_w)
  );

  // Address half of a write. awready is a one-cycle offer made every other cycle
  // while the slot is empty, so a waiting awvalid is taken within two edges.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_addr_q <= 12'h000;
      aw_have_q <= 1'b0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
    end
  end

  // Data half of a write, taken on its own so address and data may come in either order
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      w_have_q <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write response: raised on the edge that commits the write, held until bready.
  // Both readys stay low while it stands, so only one write is ever in flight.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LRC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(aw_addr_q) ? `LRC_RESP_OKAY : `LRC_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Readback mux; bits above the byte and unimplemented bits read zero because
  // the writes were already masked to the implemented bits
  // readback
  always @* begin
    rd_data_d = 32'h00000000;
    rd_hit_d = 1'b1;
    case (reg_sel(s_axi_araddr))
      2'h1: rd_data_d = {24'h000000, ref_ctrl};
      2'h2: rd_data_d = {24'h000000, port_a_dir};
      2'h3: rd_data_d = {24'h000000, cmp_ctrl};
      default: rd_hit_d = 1'b0;
    endcase
  end

  // Read address: offered every other cycle while no read data is waiting
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
    end
  end

  // Read data: captured on the edge that takes the address, so a later write cannot
  // change an answer that already stands; held until rready
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `LRC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data_d;
      s_axi_rresp <= rd_hit_d ? `LRC_RESP_OKAY : `LRC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Field taps of the register image, named once so each control below reads plainly
  wire ref_power = ref_ctrl[`LRC_BIT_POWER];
  wire ref_pin_drive = ref_ctrl[`LRC_BIT_PIN_DRIVE];
  wire ref_low_range = ref_ctrl[`LRC_BIT_LOW_RANGE];
  wire [3:0] ref_tap = ref_ctrl[`LRC_TAP_MSB:`LRC_TAP_LSB];
  wire pin2_is_input = port_a_dir[`LRC_BIT_PIN2_DIR];
  wire [2:0] cmp_cfg = cmp_ctrl[2:0];

  // Every analog control is registered once more so the top outputs come straight from
  // flops; the price is one extra edge after a write, which static controls can afford.

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ladder_power_q <= 1'b0;
    end else begin
      ladder_power_q <= ref_power;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ladder_pin_drive_q <= 1'b0;
    end else begin
      ladder_pin_drive_q <= ref_pin_drive;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ladder_low_range_q <= 1'b0;
    end else begin
      ladder_low_range_q <= ref_low_range;
    end
  end

  // Sixteen steps per range; the code passes to the ladder unchanged
  // tap code
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ladder_tap_code_q <= 4'h0;
    end else begin
      ladder_tap_code_q <= ref_tap;
    end
  end

  // Both the direction bit and the drive bit must be set, so the ladder only
  // reaches a pin that the port itself is not driving
  // pin gating
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      port_a_pin2_connect_q <= 1'b0;
    end else begin
      port_a_pin2_connect_q <= ref_pin_drive && pin2_is_input;
    end
  end

  // The mode only steers the comparator inputs; it never gates the ladder itself
  // comparator routing
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_vin_plus_ref_q <= 1'b0;
    end else begin
      cmp_vin_plus_ref_q <= (cmp_cfg == `LRC_CMP_CFG_INTREF);
    end
  end

  // Comparator mode as the comparator block sees it
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      comparator_config_q <= 3'h0;
    end else begin
      comparator_config_q <= cmp_cfg;
    end
  end

  // Bits 7 to 5 do not exist in the register, so they never reach a pin
  // port A direction
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      port_a_direction_q <= DIR_RST[4:0];
    end else begin
      port_a_direction_q <= port_a_dir[4:0];
    end
  end

  // One edge behind the other controls, because the ladder code is itself registered
  // ladder level
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ladder_level_96ths_q <= 7'h00;
    end else begin
      ladder_level_96ths_q <= level_w;
    end
  end
endmodule

// ---- test/lrc_asserts.sv ----
`include "lrc_map.vh"
module lrc_asserts (
  input wire ref_clk,
  input wire arst_n,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_bvalid,
  input wire ladder_power_q,
  input wire ladder_pin_drive_q,
  input wire ladder_low_range_q,
  input wire [3:0] ladder_tap_code_q,
  input wire port_a_pin2_connect_q,
  input wire cmp_vin_plus_ref_q,
  input wire [4:0] port_a_direction_q,
  input wire [2:0] comparator_config_q,
  input wire [6:0] ladder_level_96ths_q
);
  // Register image and level in 96ths rebuilt from the ladder controls
  wire [7:0] ctl = {ladder_power_q, ladder_pin_drive_q, ladder_low_range_q, 1'b0,
    ladder_tap_code_q};
  wire [6:0] lvl = !ladder_power_q ? 7'h0 : ladder_low_range_q ? {1'b0, ladder_tap_code_q, 2'h0}
    : 7'h18 + 7'h3 * {3'h0, ladder_tap_code_q};
  reg rd_ref_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Remembers the target of the read in flight, since rdata alone cannot tell
  always @(posedge ref_clk or negedge arst_n)
    if (!arst_n) rd_ref_q <= 1'b0;
    else if (s_axi_arvalid && s_axi_arready) rd_ref_q <= s_axi_araddr == `LRC_ADDR_REF_CTRL;
  sequence rd_ref_s;
    s_axi_rvalid && rd_ref_q;
  endsequence
  pin_gate_a: assert property (
    port_a_pin2_connect_q == (ladder_pin_drive_q && port_a_direction_q[2])) else $error("pin gate");
  cmp_route_a: assert property (
    cmp_vin_plus_ref_q == (comparator_config_q == 3'h2)) else $error("comparator route");
  level_map_a: assert property (
    ladder_level_96ths_q == $past(lvl)) else $error("ladder level");
  reset_clear_a: assert property ($rose(arst_n) |-> ctl == 8'h0) else $error("ctl reset");
  dir_reset_a: assert property (
    $rose(arst_n) |-> port_a_direction_q == 5'h1f) else $error("dir reset");
  ctl_hold_a: assert property (
    !$stable(ctl) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("ctl moved");
  ref_read_a: assert property (
    rd_ref_s |-> s_axi_rdata == {24'h0, ctl}) else $error("ref readback");
  read_upper_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper");
endmodule
bind lrc_ladder_reference_control lrc_asserts u_chk (.ref_clk, .arst_n, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_bvalid, .ladder_power_q,
  .ladder_pin_drive_q, .ladder_low_range_q, .ladder_tap_code_q, .port_a_pin2_connect_q,
  .cmp_vin_plus_ref_q, .port_a_direction_q, .comparator_config_q, .ladder_level_96ths_q);

// ---- test/lrc_ladder_reference_control_tb.sv ----
`include "lrc_map.vh"
module lrc_ladder_reference_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, ladder_power_q, ladder_pin_drive_q, ladder_low_range_q;
  logic port_a_pin2_connect_q, cmp_vin_plus_ref_q;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] comparator_config_q;
  logic [3:0] s_axi_wstrb, ladder_tap_code_q;
  logic [4:0] port_a_direction_q;
  logic [6:0] ladder_level_96ths_q;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  int bad_count, checked, ref_m, dir_m, cmp_m;
  lrc_ladder_reference_control DUT (.*);
  // Free-running 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // Address and data go out together; each is dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    cmp(s_axi_bresp, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    cmp(s_axi_rdata, e);
    cmp(s_axi_rresp, r);
  endtask
  // Level lags the controls by one more edge, so three edges cover both
  task automatic ports;
    logic [23:0] e;
    logic [23:0] g;
    e[6:0] = !ref_m[7] ? 7'h0 : ref_m[5] ? 7'h4 * ref_m[3:0] : 7'h18 + 7'h3 * ref_m[3:0];
    e[23:7] = {ref_m[7:5], ref_m[3:0], ref_m[6] & dir_m[2], cmp_m[2:0] == 3'h2, dir_m[4:0],
      cmp_m[2:0]};
    repeat (3) @(posedge ref_clk);
    g = {ladder_power_q, ladder_pin_drive_q, ladder_low_range_q, ladder_tap_code_q,
      port_a_pin2_connect_q, cmp_vin_plus_ref_q, port_a_direction_q, comparator_config_q,
      ladder_level_96ths_q};
    cmp(g, e);
  endtask
  task automatic regs;
    rd(`LRC_ADDR_REF_CTRL, ref_m, `LRC_RESP_OKAY);
    rd(`LRC_ADDR_PORT_A_DIR, dir_m, `LRC_RESP_OKAY);
    rd(`LRC_ADDR_CMP_CTRL, cmp_m, `LRC_RESP_OKAY);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog: the whole run needs about 4100 cycles, settling waits included
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    finish_test;
  end
  initial begin
    {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hf;
    {bad_count, checked, ref_m, cmp_m, dir_m} = {128'h0, 32'h1f};
    d = $urandom(32'hefaa);
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    ports;
    regs;
    $display("test reset done");
    // Every tap in both ranges, every comparator mode, junk in unused bits
    for (int i = 0; i < 32; i++) begin
      d = $urandom;
      ref_m = {1'b1, d[6], i[4], 1'b0, i[3:0]};
      wr(`LRC_ADDR_REF_CTRL, {d[31:8], 2'h2 | d[7:6], i[4], d[4], i[3:0]}, `LRC_RESP_OKAY);
      dir_m = d[12:8];
      wr(`LRC_ADDR_PORT_A_DIR, d >> 8, `LRC_RESP_OKAY);
      cmp_m = {d[3], i[2:0]};
      wr(`LRC_ADDR_CMP_CTRL, {d[31:4], d[3], i[2:0]}, `LRC_RESP_OKAY);
      ports;
      regs;
      // Software lets the ladder settle before it relies on the next setting
      repeat (`LRC_SETTLE_CYC) @(posedge ref_clk);
    end
    $display("test sweep done");
    // Powered down with a tap set gives no output
    ref_m = 8'h6b;
    wr(`LRC_ADDR_REF_CTRL, 32'h6b, `LRC_RESP_OKAY);
    ports;
    wr(12'h004, 32'hff, `LRC_RESP_SLVERR);
    rd(12'h004, 32'h0, `LRC_RESP_SLVERR);
    s_axi_wstrb <= 4'he;
    wr(`LRC_ADDR_REF_CTRL, 32'h0, `LRC_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    ports;
    regs;
    $display("test refusal done");
    // Reset in mid-run returns every register to its reset value
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    {ref_m, cmp_m, dir_m} = {64'h0, 32'h1f};
    ports;
    regs;
    $display("test mid reset done");
    finish_test;
  end
endmodule
